// ===== logic/exec_unit_pkg.sv
// shared constants and types for the integer execution unit
package exec_unit_pkg;

    // ==========================================
    // condition flag positions in the 5-bit flag word
    localparam int FX = 4;
    localparam int FN = 3;
    localparam int FZ = 2;
    localparam int FV = 1;
    localparam int FC = 0;

    // ==========================================
    // reset values and step sizes
    localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
    localparam logic [4:0]  RESET_FLAGS = 5'h00;
    localparam logic [31:0] PC_STEP     = 32'h0000_0002;
    localparam logic [31:0] STACK_STEP  = 32'h0000_0004;
    localparam logic [31:0] FLAG_STEP   = 32'h0000_0002;

    // ==========================================
    // counts and field constants
    localparam logic [5:0]  IMM_ZERO_COUNT = 6'h08;
    localparam logic [5:0]  MEM_SHIFT_COUNT = 6'h01;
    localparam int          SHIFT_MAX = 64;
    localparam logic [15:0] LOOP_EXPIRED = 16'hFFFF;
    localparam logic [7:0]  SET_ALL = 8'hFF;
    localparam logic [4:0]  DIGIT_MAX = 5'h09;
    localparam logic [9:0]  ADJ_LO = 10'h006;
    localparam logic [9:0]  ADJ_HI = 10'h060;
    localparam logic [9:0]  BCD_MAX = 10'h099;
    localparam logic [3:0]  COND_TRUE = 4'h0;
    localparam logic [3:0]  COND_FALSE = 4'h1;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_WORD = 2'b01,
        SZ_LONG = 2'b10
    } opsize_t;

    typedef enum logic [5:0] {
        OP_AND   = 6'b000000,
        OP_OR    = 6'b000001,
        OP_EOR   = 6'b000010,
        OP_NOT   = 6'b000011,
        OP_IMMEDIATE_CONJUNCTION  = 6'b000100,
        OP_ORI   = 6'b000101,
        OP_IMMEDIATE_EXCLUSIVE_DISJUNCTION  = 6'b000110,
        OP_TST   = 6'b000111,
        OP_ASL   = 6'b001000,
        OP_ASR   = 6'b001001,
        OP_LSL   = 6'b001010,
        OP_LSR   = 6'b001011,
        OP_ROL   = 6'b001100,
        OP_ROR   = 6'b001101,
        OP_EXTENDED_CIRCULAR_LEFT  = 6'b001110,
        OP_EXTENDED_CIRCULAR_RIGHT  = 6'b001111,
        OP_SWAP  = 6'b010000,
        OP_SINGLE_BIT_TEST  = 6'b010001,
        OP_SINGLE_BIT_SET  = 6'b010010,
        OP_SINGLE_BIT_CLEAR  = 6'b010011,
        OP_SINGLE_BIT_INVERT  = 6'b010100,
        OP_DADD  = 6'b010101,
        OP_DSUB  = 6'b010110,
        OP_DNEG  = 6'b010111,
        OP_BCC   = 6'b011000,
        OP_DECREMENT_AND_BRANCH  = 6'b011001,
        OP_SCC   = 6'b011010,
        OP_BRA   = 6'b011011,
        OP_CALLR = 6'b011100,
        OP_JUMP  = 6'b011101,
        OP_CALLA = 6'b011110,
        OP_RET   = 6'b011111,
        OP_RETD  = 6'b100000,
        OP_RETF  = 6'b100001,
        OP_NOP   = 6'b100010,
        OP_TRAPC = 6'b100011,
        OP_SYS   = 6'b100100
    } op_t;

endpackage

// ===== logic/cond_check.sv
// evaluation of the sixteen condition tests against the flag word
`timescale 1ns/1ps

module cond_check
    import exec_unit_pkg::*;
(
    input  wire logic [3:0] code,
    input  wire logic [4:0] flags,
    output logic            holds
);

    logic n, z, v, c;

    // ==========================================
    // condition select
    always_comb begin
        n = flags[FN];
        z = flags[FZ];
        v = flags[FV];
        c = flags[FC];
        case (code)
            4'h0: holds = 1'b1;
            4'h1: holds = 1'b0;
            4'h2: holds = !c && !z;
            4'h3: holds = c || z;
            4'h4: holds = !c;
            4'h5: holds = c;
            4'h6: holds = !z;
            4'h7: holds = z;
            4'h8: holds = !v;
            4'h9: holds = v;
            4'hA: holds = !n;
            4'hB: holds = n;
            4'hC: holds = n == v;
            4'hD: holds = n != v;
            4'hE: holds = !z && (n == v);
            4'hF: holds = z || (n != v);
            default: holds = 1'b0;
        endcase
    end

endmodule

// ===== logic/int_exec_unit.sv
// integer execution unit: logic, shifts, bit ops, decimal, program control
`timescale 1ns/1ps

// Overview of operation
// - and, or, xor, complement on all sizes
// - immediate forms combine constant with destination
// - zero test sets flags, operand untouched
// - instruction count shifts one to eight
// - register count taken modulo sixty-four
// - memory shifts: word size, one position
// - plain and extend-flag rotates, both directions
// - swap register halves in one operation
// - rotate by eight is single cycle
// - bit number immediate or from register
// - register bit ops 32 wide, memory 8
// - zero flag gets inverse of selected bit
// - bit set writes one after capture
// - decimal add, subtract, negate on bytes with extend
// - conditional branch adds sized displacement when true
// - while condition false, decrement word count, branch unless minus one
// - conditional set writes byte all ones/zeros
// - calls push return address, stack minus four
// - sixteen condition tests selectable
// - always-false condition illegal for conditional branch
// - conditional trap raised only when true
// - system, trap, flag-register ops flush pipeline
module int_exec_unit
    import exec_unit_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    input  wire logic        START,
    input  wire op_t         OP,
    input  wire opsize_t     SIZE,
    input  wire logic [3:0]  COND,
    input  wire logic [31:0] SRC,
    input  wire logic [31:0] DST,
    input  wire logic [31:0] IMM,
    input  wire logic [31:0] DISP,
    input  wire logic [31:0] EA,
    input  wire logic        MEM_OPND,
    input  wire logic        COUNT_FROM_REG,
    input  wire logic        BIT_FROM_REG,
    input  wire logic [4:0]  FLAGS,
    input  wire logic [31:0] PC,
    input  wire logic [31:0] SEQ_PC,
    input  wire logic [31:0] SP,
    input  wire logic [31:0] POP_PC,
    input  wire logic [15:0] POP_FLAGS,
    output logic             DONE,
    output logic [31:0]      RESULT,
    output logic             RESULT_WE,
    output logic [4:0]       FLAGS_OUT,
    output logic [31:0]      PC_NEXT,
    output logic [31:0]      SP_NEXT,
    output logic             PUSH_EN,
    output logic [31:0]      PUSH_ADDR,
    output logic [31:0]      PUSH_DATA,
    output logic             TRAP,
    output logic             ILLEGAL,
    output logic             FLUSH
);

    logic        cond_true;
    logic [31:0] next_res, next_pc, next_sp, next_push_addr;
    logic        next_we, next_push, next_trap, next_illegal, next_flush;
    logic [4:0]  next_flags;
    logic [31:0] mask, r, v, disp_ext, target, opnd;
    logic [5:0]  cnt;
    logic [4:0]  bn;
    logic [15:0] dec;
    logic [9:0]  t;
    logic [4:0]  lo;
    logic [7:0]  ds, dd;
    logic        o, ins, x, c, ovf, old_msb, left, sel, carry;
    int          m;

    cond_check u_cond (
        .code  (COND),
        .flags (FLAGS),
        .holds (cond_true)
    );

    // ==========================================
    // next-state computation
    // every count resolves in one cycle, so rotate by eight is as fast as any
    always_comb begin
        next_res = DST;
        next_we = 1'b0;
        next_flags = FLAGS;
        next_pc = SEQ_PC;
        next_sp = SP;
        next_push = 1'b0;
        next_push_addr = SP - STACK_STEP;
        next_trap = 1'b0;
        next_illegal = 1'b0;
        next_flush = 1'b0;
        r = RESET_WORD;
        v = RESET_WORD;
        o = 1'b0;
        ins = 1'b0;
        c = 1'b0;
        ovf = 1'b0;
        old_msb = 1'b0;
        sel = 1'b0;
        carry = 1'b0;
        t = 10'h000;
        lo = 5'h00;
        dec = DST[15:0] - 16'h0001;
        x = FLAGS[FX];
        left = OP inside {OP_ASL, OP_LSL, OP_ROL, OP_EXTENDED_CIRCULAR_LEFT};
        // memory shifts are forced to word size
        case ((OP inside {[OP_ASL:OP_EXTENDED_CIRCULAR_RIGHT]} && MEM_OPND) ? SZ_WORD : SIZE)
            SZ_BYTE: begin mask = 32'h0000_00FF; m = 7; end
            SZ_WORD: begin mask = 32'h0000_FFFF; m = 15; end
            default: begin mask = 32'hFFFF_FFFF; m = 31; end
        endcase
        if (MEM_OPND)
            cnt = MEM_SHIFT_COUNT;
        else if (COUNT_FROM_REG)
            cnt = SRC[5:0];
        else if (IMM[2:0] == 3'h0)
            cnt = IMM_ZERO_COUNT;
        else
            cnt = {3'h0, IMM[2:0]};
        // register operands use 32 bit numbers, memory bytes 8
        bn = BIT_FROM_REG ? SRC[4:0] : IMM[4:0];
        if (MEM_OPND)
            bn[4:3] = 2'h0;
        case (SIZE)
            SZ_BYTE: disp_ext = {{24{DISP[7]}}, DISP[7:0]};
            SZ_WORD: disp_ext = {{16{DISP[15]}}, DISP[15:0]};
            default: disp_ext = DISP;
        endcase
        target = PC + PC_STEP + disp_ext;
        opnd = (OP inside {OP_IMMEDIATE_CONJUNCTION, OP_ORI, OP_IMMEDIATE_EXCLUSIVE_DISJUNCTION}) ? IMM : SRC;
        ds = (OP == OP_DNEG) ? DST[7:0] : SRC[7:0];
        dd = (OP == OP_DNEG) ? 8'h00 : DST[7:0];
        case (OP)
            OP_AND, OP_IMMEDIATE_CONJUNCTION, OP_OR, OP_ORI, OP_EOR, OP_IMMEDIATE_EXCLUSIVE_DISJUNCTION, OP_NOT, OP_TST: begin
                case (OP)
                    OP_AND, OP_IMMEDIATE_CONJUNCTION: r = DST & opnd;
                    OP_OR, OP_ORI:   r = DST | opnd;
                    OP_EOR, OP_IMMEDIATE_EXCLUSIVE_DISJUNCTION: r = DST ^ opnd;
                    OP_NOT:          r = ~DST;
                    default:         r = DST;
                endcase
                next_res = (DST & ~mask) | (r & mask);
                next_we = (OP != OP_TST);
                next_flags[FN] = r[m];
                next_flags[FZ] = (r & mask) == RESET_WORD;
                next_flags[FV] = 1'b0;
                next_flags[FC] = 1'b0;
            end
            OP_ASL, OP_ASR, OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_EXTENDED_CIRCULAR_LEFT, OP_EXTENDED_CIRCULAR_RIGHT: begin
                v = DST & mask;
                for (int i = 0; i < SHIFT_MAX; i++) begin
                    if (i < int'(cnt)) begin
                        old_msb = v[m];
                        o = left ? v[m] : v[0];
                        case (OP)
                            OP_ASR:           ins = v[m];
                            OP_ROL, OP_ROR:   ins = o;
                            OP_EXTENDED_CIRCULAR_LEFT, OP_EXTENDED_CIRCULAR_RIGHT: ins = x;
                            default:          ins = 1'b0;
                        endcase
                        if (left) begin
                            v = {v[30:0], 1'b0};
                            v[0] = ins;
                        end else begin
                            v = {1'b0, v[31:1]};
                            v[m] = ins;
                        end
                        if (OP == OP_ASL && v[m] != old_msb)
                            ovf = 1'b1;
                        c = o;
                        if (!(OP inside {OP_ROL, OP_ROR}))
                            x = o;
                    end
                end
                v = v & mask;
                next_res = (DST & ~mask) | v;
                next_we = 1'b1;
                next_flags[FX] = x;
                next_flags[FN] = v[m];
                next_flags[FZ] = v == RESET_WORD;
                next_flags[FV] = ovf;
                next_flags[FC] = (cnt == 6'h00) ? (OP inside {OP_EXTENDED_CIRCULAR_LEFT, OP_EXTENDED_CIRCULAR_RIGHT}) && x : c;
            end
            OP_SWAP: begin
                next_res = {DST[15:0], DST[31:16]};
                next_we = 1'b1;
                next_flags[FN] = DST[15];
                next_flags[FZ] = DST == RESET_WORD;
                next_flags[FV] = 1'b0;
                next_flags[FC] = 1'b0;
            end
            OP_SINGLE_BIT_TEST, OP_SINGLE_BIT_SET, OP_SINGLE_BIT_CLEAR, OP_SINGLE_BIT_INVERT: begin
                sel = DST[bn];
                next_flags[FZ] = ~sel;
                case (OP)
                    OP_SINGLE_BIT_SET: next_res[bn] = 1'b1;
                    OP_SINGLE_BIT_CLEAR: next_res[bn] = 1'b0;
                    OP_SINGLE_BIT_INVERT: next_res[bn] = ~sel;
                    default: next_res = DST;
                endcase
                next_we = (OP != OP_SINGLE_BIT_TEST);
            end
            OP_DADD, OP_DSUB, OP_DNEG: begin
                if (OP == OP_DADD) begin
                    lo = {1'b0, dd[3:0]} + {1'b0, ds[3:0]} + {4'h0, FLAGS[FX]};
                    t = {2'h0, dd} + {2'h0, ds} + {9'h000, FLAGS[FX]};
                    if (lo > DIGIT_MAX)
                        t = t + ADJ_LO;
                    carry = t > BCD_MAX;
                    if (carry)
                        t = t + ADJ_HI;
                end else begin
                    lo = {1'b0, ds[3:0]} + {4'h0, FLAGS[FX]};
                    t = {2'h0, dd} - {2'h0, ds} - {9'h000, FLAGS[FX]};
                    if ({1'b0, dd[3:0]} < lo)
                        t = t - ADJ_LO;
                    carry = {2'h0, dd} < ({2'h0, ds} + {9'h000, FLAGS[FX]});
                    if (carry)
                        t = t - ADJ_HI;
                end
                next_res = {DST[31:8], t[7:0]};
                next_we = 1'b1;
                next_flags[FX] = carry;
                next_flags[FC] = carry;
                next_flags[FN] = t[7];
                next_flags[FV] = 1'b0;
                // zero only clears, so multi-byte chains keep a running test
                if (t[7:0] != 8'h00)
                    next_flags[FZ] = 1'b0;
            end
            OP_BCC: begin
                if (COND == COND_FALSE)
                    next_illegal = 1'b1;
                else if (cond_true)
                    next_pc = target;
            end
            OP_DECREMENT_AND_BRANCH: begin
                if (!cond_true) begin
                    next_res = {DST[31:16], dec};
                    next_we = 1'b1;
                    if (dec != LOOP_EXPIRED)
                        next_pc = target;
                end
            end
            OP_SCC: begin
                next_res = {DST[31:8], cond_true ? SET_ALL : 8'h00};
                next_we = 1'b1;
            end
            OP_BRA:   next_pc = target;
            OP_JUMP:  next_pc = EA;
            OP_CALLR, OP_CALLA: begin
                next_sp = SP - STACK_STEP;
                next_push = 1'b1;
                next_pc = (OP == OP_CALLR) ? target : EA;
            end
            OP_RET: begin
                next_pc = POP_PC;
                next_sp = SP + STACK_STEP;
            end
            OP_RETD: begin
                next_pc = POP_PC;
                next_sp = SP + STACK_STEP + {{16{DISP[15]}}, DISP[15:0]};
            end
            OP_RETF: begin
                next_flags = POP_FLAGS[4:0];
                next_pc = POP_PC;
                next_sp = SP + FLAG_STEP + STACK_STEP;
                next_flush = 1'b1;
            end
            OP_NOP:   next_pc = PC + PC_STEP;
            OP_TRAPC: begin
                next_trap = cond_true;
                next_flush = 1'b1;
            end
            OP_SYS:   next_flush = 1'b1;
            default:  next_illegal = 1'b1;
        endcase
    end

    // ==========================================
    // operand result and flags
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            RESULT <= RESET_WORD;
            RESULT_WE <= 1'b0;
            FLAGS_OUT <= RESET_FLAGS;
        end else begin
            RESULT <= next_res;
            RESULT_WE <= START && next_we;
            FLAGS_OUT <= next_flags;
        end
    end

    // ==========================================
    // program flow and stack
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            PC_NEXT <= RESET_WORD;
            SP_NEXT <= RESET_WORD;
            PUSH_EN <= 1'b0;
            PUSH_ADDR <= RESET_WORD;
            PUSH_DATA <= RESET_WORD;
        end else begin
            PC_NEXT <= next_pc;
            SP_NEXT <= next_sp;
            PUSH_EN <= START && next_push;
            PUSH_ADDR <= next_push_addr;
            PUSH_DATA <= SEQ_PC;
        end
    end

    // ==========================================
    // completion, trap and flush strobes
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            DONE <= 1'b0;
            TRAP <= 1'b0;
            ILLEGAL <= 1'b0;
            FLUSH <= 1'b0;
        end else begin
            DONE <= START;
            TRAP <= START && next_trap;
            ILLEGAL <= START && next_illegal;
            FLUSH <= START && next_flush;
        end
    end

    // ==========================================
    // checks
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    swap_halves_a: assert property (START && OP == OP_SWAP |=> RESULT_WE &&
        RESULT == {$past(DST[15:0]), $past(DST[31:16])}) else $error("swap wrong");
    zero_test_a: assert property (START && OP == OP_TST |=> !RESULT_WE &&
        FLAGS_OUT[FZ] == (($past(DST) & $past(mask)) == RESET_WORD)) else $error("test wrong");
    bit_set_a: assert property (START && OP == OP_SINGLE_BIT_SET |=> RESULT_WE &&
        FLAGS_OUT[FZ] == !$past(sel) && RESULT[$past(bn)]) else $error("bit set wrong");
    call_push_a: assert property (START && OP inside {OP_CALLR, OP_CALLA} |=>
        PUSH_EN && SP_NEXT == $past(SP) - STACK_STEP && PUSH_ADDR == SP_NEXT)
        else $error("call push wrong");
    nop_advance_a: assert property (START && OP == OP_NOP |=> !RESULT_WE &&
        !PUSH_EN && PC_NEXT == $past(PC) + PC_STEP) else $error("nop wrong");
    branch_false_a: assert property (START && OP == OP_BCC && COND == COND_FALSE
        |=> ILLEGAL) else $error("false branch accepted");
    trap_cond_a: assert property (START && OP == OP_TRAPC |=> FLUSH &&
        TRAP == $past(cond_true)) else $error("trap wrong");
    flag_return_a: assert property (START && OP == OP_RETF |=> FLUSH &&
        FLAGS_OUT == $past(POP_FLAGS[4:0])) else $error("flag return wrong");
    loop_count_a: assert property (START && OP == OP_DECREMENT_AND_BRANCH && !cond_true &&
        DST[15:0] == 16'h0000 |=> RESULT[15:0] == LOOP_EXPIRED && PC_NEXT == $past(SEQ_PC))
        else $error("loop exit wrong");
    cond_set_a: assert property (START && OP == OP_SCC |=> RESULT[7:0] ==
        ($past(cond_true) ? SET_ALL : 8'h00)) else $error("set byte wrong");
    done_pulse_a: assert property (START |=> DONE ##1 (DONE == $past(START)))
        else $error("done wrong");

    rot_eight_c: cover property (START && OP == OP_ROL && cnt == IMM_ZERO_COUNT);
    branch_taken_c: cover property (START && OP == OP_BCC && cond_true ##1 DONE);
    decimal_carry_c: cover property (START && OP == OP_DADD ##1 FLAGS_OUT[FC]);
    loop_back_c: cover property (START && OP == OP_DECREMENT_AND_BRANCH && !cond_true);

endmodule

// ===== tb/tb.sv
// self-checking bench for the integer execution unit
`timescale 1ns/1ps

module tb;
    import exec_unit_pkg::*;

    // ==========================================
    // stimulus and observed signals
    logic        SYS_CLK = 1'b0;
    logic        RST = 1'b1;
    logic        START = 1'b0;
    op_t         OP = OP_NOP;
    opsize_t     SIZE = SZ_BYTE;
    logic [3:0]  COND = 4'h0;
    logic [31:0] SRC = 32'h0, DST = 32'h0, IMM = 32'h0, DISP = 32'h0, EA = 32'h0;
    logic [31:0] PC = 32'h0, SEQ_PC = 32'h0, SP = 32'h0, POP_PC = 32'h0;
    logic        MEM_OPND = 1'b0, COUNT_FROM_REG = 1'b0, BIT_FROM_REG = 1'b0;
    logic [4:0]  FLAGS = 5'h00;
    logic [15:0] POP_FLAGS = 16'h0;
    logic        DONE, RESULT_WE, PUSH_EN, TRAP, ILLEGAL, FLUSH;
    logic [31:0] RESULT, PC_NEXT, SP_NEXT, PUSH_ADDR, PUSH_DATA;
    logic [4:0]  FLAGS_OUT;
    int          err_total = 0;
    int          compares = 0;
    logic [4:0]  fset [7] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h0A, 5'h05};

    int_exec_unit i_dut (.*);

    always #10 SYS_CLK = ~SYS_CLK;

    // ==========================================
    // shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // control-flow context, held steady across the following operations
    task automatic ctx(input logic [31:0] d, e, p, q, s, pp, input logic [15:0] pf);
        @(posedge SYS_CLK);
        DISP <= d;
        EA <= e;
        PC <= p;
        SEQ_PC <= q;
        SP <= s;
        POP_PC <= pp;
        POP_FLAGS <= pf;
    endtask

    // one operation: start pulse, then outputs read in the done cycle
    task automatic go(input op_t o, input opsize_t s, input logic [3:0] c,
                      input logic [31:0] src, dst, imm, input logic [4:0] f,
                      input logic [2:0] m);
        @(posedge SYS_CLK);
        START <= 1'b1;
        OP <= o;
        SIZE <= s;
        COND <= c;
        SRC <= src;
        DST <= dst;
        IMM <= imm;
        FLAGS <= f;
        {MEM_OPND, COUNT_FROM_REG, BIT_FROM_REG} <= m;
        @(posedge SYS_CLK);
        START <= 1'b0;
        #1;
        chk(32'(DONE), 32'h1);
    endtask

    // reference evaluation of the condition tests, written independently
    function automatic logic cc(input logic [3:0] c, input logic [4:0] f);
        logic n, z, v, k;
        n = f[FN];
        z = f[FZ];
        v = f[FV];
        k = f[FC];
        case (c)
            4'h0: return 1'b1;
            4'h1: return 1'b0;
            4'h2: return !k && !z;
            4'h3: return k || z;
            4'h4: return !k;
            4'h5: return k;
            4'h6: return !z;
            4'h7: return z;
            4'h8: return !v;
            4'h9: return v;
            4'hA: return !n;
            4'hB: return n;
            4'hC: return n == v;
            4'hD: return n != v;
            4'hE: return (n == v) && !z;
            default: return (n != v) || z;
        endcase
    endfunction

    // ==========================================
    // hang guard: the whole sequence needs well under 20 us
    initial begin
        #200000;
        err_total++;
        final_report();
    end

    // ==========================================
    // test sequence
    initial begin
        repeat (6) @(posedge SYS_CLK);
        RST <= 1'b0;
        go(OP_AND, SZ_BYTE, 0, 32'h0F0F0F0F, 32'h12345678, 0, 5'h1F, 0);
        chk(RESULT, 32'h12345608);
        chk(32'(FLAGS_OUT), 32'h10);
        go(OP_OR, SZ_WORD, 0, 32'h0000F00F, 32'h12340FF0, 0, 5'h00, 0);
        chk(RESULT, 32'h1234FFFF);
        go(OP_EOR, SZ_LONG, 0, 32'hFFFFFFFF, 32'h12345678, 0, 5'h00, 0);
        chk(RESULT, 32'hEDCBA987);
        go(OP_NOT, SZ_BYTE, 0, 0, 32'h123456FF, 0, 5'h00, 0);
        chk(RESULT, 32'h12345600);
        chk(32'(FLAGS_OUT), 32'h04);
        go(OP_IMMEDIATE_CONJUNCTION, SZ_WORD, 0, 0, 32'hABCD1234, 32'h000000FF, 5'h00, 0);
        chk(RESULT, 32'hABCD0034);
        go(OP_ORI, SZ_BYTE, 0, 0, 32'h0, 32'h80, 5'h00, 0);
        chk(RESULT, 32'h00000080);
        go(OP_IMMEDIATE_EXCLUSIVE_DISJUNCTION, SZ_LONG, 0, 0, 32'hFFFF0000, 32'hFFFF0000, 5'h00, 0);
        chk(RESULT, 32'h0);
        go(OP_TST, SZ_BYTE, 0, 0, 32'h00000100, 0, 5'h00, 0);
        chk(32'(FLAGS_OUT), 32'h04);
        chk(32'(RESULT_WE), 32'h0);
        go(OP_LSL, SZ_LONG, 0, 0, 32'h12345678, 32'h0, 5'h00, 0);
        chk(RESULT, 32'h34567800);
        go(OP_LSR, SZ_LONG, 0, 32'h41, 32'h80000001, 0, 5'h00, 3'b010);
        chk(RESULT, 32'h40000000);
        chk(32'(FLAGS_OUT), 32'h11);
        go(OP_ASL, SZ_LONG, 0, 0, 32'h0000C001, 32'h3, 5'h00, 3'b100);
        chk(RESULT, 32'h00008002);
        chk(32'(FLAGS_OUT), 32'h19);
        go(OP_ASR, SZ_BYTE, 0, 0, 32'h81, 32'h1, 5'h00, 0);
        chk(RESULT, 32'hC0);
        chk(32'(FLAGS_OUT), 32'h19);
        go(OP_ROL, SZ_LONG, 0, 0, 32'h12345678, 32'h0, 5'h00, 0);
        chk(RESULT, 32'h34567812);
        go(OP_ROR, SZ_BYTE, 0, 0, 32'h01, 32'h1, 5'h00, 0);
        chk(RESULT, 32'h80);
        go(OP_EXTENDED_CIRCULAR_LEFT, SZ_BYTE, 0, 0, 32'h80, 32'h1, 5'h10, 0);
        chk(RESULT, 32'h01);
        chk(32'(FLAGS_OUT), 32'h11);
        go(OP_EXTENDED_CIRCULAR_RIGHT, SZ_BYTE, 0, 0, 32'h01, 32'h1, 5'h00, 0);
        chk(32'(FLAGS_OUT), 32'h15);
        go(OP_SWAP, SZ_LONG, 0, 0, 32'h12345678, 0, 5'h00, 0);
        chk(RESULT, 32'h56781234);
        go(OP_SINGLE_BIT_SET, SZ_LONG, 0, 0, 32'h0, 32'd31, 5'h00, 0);
        chk(RESULT, 32'h80000000);
        chk(32'(FLAGS_OUT), 32'h04);
        go(OP_SINGLE_BIT_CLEAR, SZ_LONG, 0, 32'h1, 32'h2, 32'd5, 5'h00, 3'b001);
        chk(RESULT, 32'h0);
        chk(32'(FLAGS_OUT), 32'h00);
        go(OP_SINGLE_BIT_INVERT, SZ_BYTE, 0, 0, 32'h02, 32'd9, 5'h1F, 3'b100);
        chk(RESULT, 32'h0);
        chk(32'(FLAGS_OUT), 32'h1B);
        go(OP_SINGLE_BIT_TEST, SZ_LONG, 0, 0, 32'h0, 32'd4, 5'h00, 0);
        chk(32'(FLAGS_OUT), 32'h04);
        go(OP_DADD, SZ_BYTE, 0, 32'h45, 32'h38, 0, 5'h14, 0);
        chk(RESULT, 32'h84);
        go(OP_DSUB, SZ_BYTE, 0, 32'h25, 32'h50, 0, 5'h10, 0);
        chk(RESULT, 32'h24);
        go(OP_DNEG, SZ_BYTE, 0, 0, 32'h01, 0, 5'h00, 0);
        chk(RESULT, 32'h99);
        chk(32'({FLAGS_OUT[FX], FLAGS_OUT[FC]}), 32'h3);
        ctx(32'hF0, 32'h4000, 32'h100, 32'h102, 32'h1000, 32'h2222, 16'h0013);
        go(OP_BCC, SZ_BYTE, 4'h7, 0, 0, 0, 5'h04, 0);
        chk(PC_NEXT, 32'hF2);
        go(OP_BCC, SZ_BYTE, 4'h6, 0, 0, 0, 5'h04, 0);
        chk(PC_NEXT, 32'h102);
        go(OP_BCC, SZ_BYTE, 4'h1, 0, 0, 0, 5'h04, 0);
        chk(32'(ILLEGAL), 32'h1);
        chk(PC_NEXT, 32'h102);
        go(OP_BRA, SZ_LONG, 4'h0, 0, 0, 0, 5'h00, 0);
        chk(PC_NEXT, 32'h1F2);
        go(OP_DECREMENT_AND_BRANCH, SZ_WORD, 4'h1, 0, 32'h12340005, 0, 5'h00, 0);
        chk(RESULT, 32'h12340004);
        chk(PC_NEXT, 32'h1F2);
        go(OP_DECREMENT_AND_BRANCH, SZ_WORD, 4'h1, 0, 32'h12340000, 0, 5'h00, 0);
        chk(RESULT, 32'h1234FFFF);
        chk(PC_NEXT, 32'h102);
        // every condition code against a spread of flag words
        foreach (fset[i]) begin
            for (int c = 0; c < 16; c++) begin
                go(OP_SCC, SZ_BYTE, 4'(c), 0, 32'hAAAAAA55, 0, fset[i], 0);
                chk(RESULT, {24'hAAAAAA, cc(4'(c), fset[i]) ? 8'hFF : 8'h00});
            end
        end
        go(OP_SCC, SZ_BYTE, 4'h1, 0, 32'h000000FF, 0, 5'h00, 0);
        chk(RESULT, 32'h0);
        go(OP_CALLR, SZ_BYTE, 0, 0, 0, 0, 5'h00, 0);
        chk(PUSH_ADDR, 32'hFFC);
        chk(PUSH_DATA, 32'h102);
        chk(SP_NEXT, 32'hFFC);
        chk(PC_NEXT, 32'hF2);
        chk(32'(PUSH_EN), 32'h1);
        go(OP_CALLA, SZ_LONG, 0, 0, 0, 0, 5'h00, 0);
        chk(PC_NEXT, 32'h4000);
        go(OP_RET, SZ_LONG, 0, 0, 0, 0, 5'h00, 0);
        chk(PC_NEXT, 32'h2222);
        chk(SP_NEXT, 32'h1004);
        go(OP_RETD, SZ_WORD, 0, 0, 0, 0, 5'h00, 0);
        chk(SP_NEXT, 32'h10F4);
        go(OP_RETF, SZ_LONG, 0, 0, 0, 0, 5'h00, 0);
        chk(32'(FLAGS_OUT), 32'h13);
        chk(SP_NEXT, 32'h1006);
        chk(32'(FLUSH), 32'h1);
        go(OP_TRAPC, SZ_LONG, 4'h0, 0, 0, 0, 5'h00, 0);
        chk(32'({TRAP, FLUSH}), 32'h3);
        go(OP_TRAPC, SZ_LONG, 4'h1, 0, 0, 0, 5'h00, 0);
        chk(32'({TRAP, FLUSH}), 32'h1);
        go(OP_SYS, SZ_LONG, 0, 0, 0, 0, 5'h00, 0);
        chk(32'(FLUSH), 32'h1);
        go(OP_NOP, SZ_LONG, 0, 0, 0, 0, 5'h00, 0);
        chk(PC_NEXT, 32'h102);
        chk(SP_NEXT, 32'h1000);
        chk(32'({RESULT_WE, PUSH_EN}), 32'h0);
        final_report();
    end
endmodule
